// [verilog/rif_pkg.sv]
// constants for the reader interrupt flag registers
`default_nettype none
package rif_pkg;
	// register data and address widths
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned MEAS_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_MASK_MAIN  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MASK_TIMER = 8'h15;
	localparam logic [ADDR_W-1:0] OFS_MASK_ERR   = 8'h16;
	localparam logic [ADDR_W-1:0] OFS_MAIN       = 8'h17;
	localparam logic [ADDR_W-1:0] OFS_TIMER      = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_ERR        = 8'h19;

	// reset values
	localparam logic [DATA_W-1:0] RST_FLAGS = 8'h00;
	localparam logic [DATA_W-1:0] RST_MASK  = 8'h00;
	localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

	// main flag register fields
	localparam int unsigned MAIN_OSC = 7;
	localparam int unsigned MAIN_FIFO_LEVEL = 6;
	localparam int unsigned MAIN_RX_START = 5;
	localparam int unsigned MAIN_RX_END = 4;
	localparam int unsigned MAIN_TX_END = 3;
	localparam int unsigned MAIN_COLL = 2;
	localparam int unsigned MAIN_SUM_TIMER = 1;
	localparam int unsigned MAIN_SUM_ERR = 0;
	// main bits cleared by their own read; summary bits are not
	localparam logic [DATA_W-1:0] MAIN_RC_BITS = 8'hfc;

	// timer and field event register fields
	localparam int unsigned TMR_CMD_DONE = 7;
	localparam int unsigned TMR_NRT = 6;
	localparam int unsigned TMR_GPT = 5;
	localparam int unsigned TMR_FIELD_ON = 4;
	localparam int unsigned TMR_FIELD_OFF = 3;
	localparam int unsigned TMR_CA_COLL = 2;
	localparam int unsigned TMR_CA_GUARD = 1;
	localparam int unsigned TMR_RATE = 0;

	// error and wake-up register fields
	localparam int unsigned ERR_CRC = 7;
	localparam int unsigned ERR_PAR = 6;
	localparam int unsigned ERR_SOFT = 5;
	localparam int unsigned ERR_HARD = 4;
	localparam int unsigned ERR_WAKE = 3;
	localparam int unsigned ERR_AMP = 2;
	localparam int unsigned ERR_PHASE = 1;
	localparam int unsigned ERR_CAP = 0;

	// kind of wake-up measurement being reported
	typedef enum logic [1:0] {
		RIF_MEAS_AMP   = 2'h0,
		RIF_MEAS_PHASE = 2'h1,
		RIF_MEAS_CAP   = 2'h3
	} rif_meas_e;
endpackage // rif_pkg
`default_nettype wire

// [verilog/rif_flags.sv]
// interrupt flag registers, masks and request output of the reader front end
// Functional notes
// - set oscillator-stable main bit 7 once oscillator runs after enable
// - set FIFO level main bit 6 when receive FIFO nearly full
// - set same FIFO level bit when transmit FIFO nearly empty
// - main bit 5 start of receive, bit 4 end receive, bit 3 end transmit
// - main bit 2 set on every detected bit collision
// - main bit 1 summarises pending timer and field flags
// - main bit 0 summarises pending error and wake-up flags
// - reading main clears bits 7 to 2, not the summary bits
// - summary bit clears only on read of its secondary register
// - all flag registers zero after reset and set-default command
// - timer bit 7 command done, bit 6 no-response, bit 5 general timer
// - timer bit 4 field rises above level, bit 3 falls below
// - timer bit 2 external field seen during collision avoidance
// - timer bit 1 field switched on after guard time, none seen
// - timer bit 0 initiator bit rate recognised in target mode
// - reading main also clears both secondary flag registers
// - error bit 5 soft framing error, data intact
// - error bit 4 hard framing error, data corrupted
// - error bit 3 wake timer timeout when every-timeout option selected
// - error bit 2 amplitude differs from reference beyond delta
// - error bit 1 phase differs from reference beyond delta
// - error bit 0 capacitance differs from reference beyond delta
// - mask bit 1 blocks its event from request, default unmasked
//
// The plain strobed port was left to the implementer.
`default_nettype none
module rif_flags (
	input  wire logic                         clk_sys,
	input  wire logic                         rst_b,
	// register port
	input  wire logic [rif_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [rif_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [rif_pkg::DATA_W-1:0]   reg_rdata,
	// set-default command, one cycle
	input  wire logic                         set_default,
	// oscillator
	input  wire logic                         osc_enable,
	input  wire logic                         osc_running,
	// FIFO and framing
	input  wire logic                         rx_active,
	input  wire logic                         tx_active,
	input  wire logic                         fifo_nearly_full,
	input  wire logic                         fifo_nearly_empty,
	input  wire logic                         rx_start,
	input  wire logic                         rx_end,
	input  wire logic                         tx_end,
	input  wire logic                         bit_collision,
	// timers and field events
	input  wire logic                         cmd_done,
	input  wire logic                         nrt_expired,
	input  wire logic                         gpt_expired,
	input  wire logic                         ext_field_async,
	input  wire logic                         ca_field_seen,
	input  wire logic                         ca_guard_done,
	input  wire logic                         target_rate_found,
	// receive errors
	input  wire logic                         crc_error,
	input  wire logic                         parity_error,
	input  wire logic                         soft_framing_error,
	input  wire logic                         hard_framing_error,
	// wake-up
	input  wire logic                         wake_timeout,
	input  wire logic                         wake_irq_every,
	input  wire logic                         meas_valid,
	input  wire logic [1:0]                   meas_kind,
	input  wire logic [rif_pkg::MEAS_W-1:0]   meas_value,
	input  wire logic [rif_pkg::MEAS_W-1:0]   meas_ref,
	input  wire logic [rif_pkg::MEAS_W-1:0]   meas_delta,
	// interrupt request
	output logic                              irq
);

	localparam int unsigned DW = rif_pkg::DATA_W;
	localparam int unsigned MW = rif_pkg::MEAS_W;

	// flag registers and their next values
	logic [DW-1:0] main_q;
	logic [DW-1:0] main_d;
	logic [DW-1:0] timer_q;
	logic [DW-1:0] timer_d;
	logic [DW-1:0] err_q;
	logic [DW-1:0] err_d;

	// software written masks
	logic [DW-1:0] mask_main_q;
	logic [DW-1:0] mask_timer_q;
	logic [DW-1:0] mask_err_q;

	// events arriving this cycle
	logic [DW-1:0] main_set;
	logic [DW-1:0] timer_set;
	logic [DW-1:0] err_set;

	// read decodes, one per flag register
	logic          rd_main;
	logic          rd_timer;
	logic          rd_err;

	// field synchroniser and level history
	logic          field_meta_q;
	logic          field_sync_q;
	logic          field_prev_q;
	logic          osc_prev_q;
	logic          fifo_cond;
	logic          fifo_prev_q;

	// wake-up measurement compare and read data
	logic [MW-1:0] meas_diff;
	logic          meas_over;
	logic [DW-1:0] rdata_d;

	// read strobes of the three flag registers
	assign rd_main  = reg_rd && (reg_addr == rif_pkg::OFS_MAIN);
	assign rd_timer = reg_rd && (reg_addr == rif_pkg::OFS_TIMER);
	assign rd_err   = reg_rd && (reg_addr == rif_pkg::OFS_ERR);

	// field detector is analog, so it is synchronised first
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			field_meta_q <= 1'b0;
			field_sync_q <= 1'b0;
		end else begin
			field_meta_q <= ext_field_async;
			field_sync_q <= field_meta_q;
		end
	end

	// previous levels for edge detection
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			field_prev_q <= 1'b0;
			osc_prev_q   <= 1'b0;
			fifo_prev_q  <= 1'b0;
		end else begin
			field_prev_q <= field_sync_q;
			osc_prev_q   <= osc_running && osc_enable;
			fifo_prev_q  <= fifo_cond;
		end
	end

	// water level is a level; flag only on its rising edge so a read
	// is not immediately undone while the level stays
	// receive nearly full or transmit nearly empty
	assign fifo_cond = (rx_active && fifo_nearly_full) ||
		(tx_active && fifo_nearly_empty);

	// absolute difference of measurement and its reference
	always_comb begin
		if (meas_value >= meas_ref) begin
			meas_diff = meas_value - meas_ref;
		end else begin
			meas_diff = meas_ref - meas_value;
		end
	end
	// strictly larger than delta counts as a change
	assign meas_over = meas_valid && (meas_diff > meas_delta);

	// main register set terms
	always_comb begin
		main_set = '0;
		main_set[rif_pkg::MAIN_OSC] = osc_running && osc_enable && !osc_prev_q;
		main_set[rif_pkg::MAIN_FIFO_LEVEL] = fifo_cond && !fifo_prev_q;
		main_set[rif_pkg::MAIN_RX_START] = rx_start;
		main_set[rif_pkg::MAIN_RX_END]   = rx_end;
		main_set[rif_pkg::MAIN_TX_END]   = tx_end;
		main_set[rif_pkg::MAIN_COLL] = bit_collision;
		// timer summary follows new timer flags
		main_set[rif_pkg::MAIN_SUM_TIMER] = |timer_set;
		// error summary follows new error flags
		main_set[rif_pkg::MAIN_SUM_ERR] = |err_set;
	end

	// timer and field register set terms
	always_comb begin
		timer_set = '0;
		timer_set[rif_pkg::TMR_CMD_DONE] = cmd_done;
		timer_set[rif_pkg::TMR_NRT]      = nrt_expired;
		timer_set[rif_pkg::TMR_GPT]      = gpt_expired;
		timer_set[rif_pkg::TMR_FIELD_ON]  = field_sync_q && !field_prev_q;
		timer_set[rif_pkg::TMR_FIELD_OFF] = !field_sync_q && field_prev_q;
		timer_set[rif_pkg::TMR_CA_COLL] = ca_field_seen;
		// own field on after guard time
		timer_set[rif_pkg::TMR_CA_GUARD] = ca_guard_done;
		timer_set[rif_pkg::TMR_RATE] = target_rate_found;
	end

	// error and wake-up register set terms
	always_comb begin
		err_set = '0;
		err_set[rif_pkg::ERR_CRC] = crc_error;
		err_set[rif_pkg::ERR_PAR] = parity_error;
		err_set[rif_pkg::ERR_SOFT] = soft_framing_error;
		err_set[rif_pkg::ERR_HARD] = hard_framing_error;
		err_set[rif_pkg::ERR_WAKE] = wake_timeout && wake_irq_every;
		err_set[rif_pkg::ERR_AMP] = meas_over &&
			(meas_kind == rif_pkg::RIF_MEAS_AMP);
		err_set[rif_pkg::ERR_PHASE] = meas_over &&
			(meas_kind == rif_pkg::RIF_MEAS_PHASE);
		err_set[rif_pkg::ERR_CAP] = meas_over &&
			(meas_kind == rif_pkg::RIF_MEAS_CAP);
	end

	// next flag values: an event in the clearing cycle survives
	always_comb begin
		main_d = main_q;
		// own read clears event bits only
		if (rd_main) begin
			main_d = main_q & ~rif_pkg::MAIN_RC_BITS;
		end
		if (rd_timer) begin
			main_d[rif_pkg::MAIN_SUM_TIMER] = 1'b0;
		end
		if (rd_err) begin
			main_d[rif_pkg::MAIN_SUM_ERR] = 1'b0;
		end
		main_d = main_d | main_set;
	end

	always_comb begin
		timer_d = timer_q;
		if (rd_timer || rd_main) begin
			timer_d = rif_pkg::RST_FLAGS;
		end
		timer_d = timer_d | timer_set;
	end

	always_comb begin
		err_d = err_q;
		if (rd_err || rd_main) begin
			err_d = rif_pkg::RST_FLAGS;
		end
		err_d = err_d | err_set;
	end

	// main flag register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			main_q <= rif_pkg::RST_FLAGS;
		end else if (set_default) begin
			main_q <= rif_pkg::RST_FLAGS;
		end else begin
			main_q <= main_d;
		end
	end

	// timer and field flag register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			timer_q <= rif_pkg::RST_FLAGS;
		end else if (set_default) begin
			timer_q <= rif_pkg::RST_FLAGS;
		end else begin
			timer_q <= timer_d;
		end
	end

	// error and wake-up flag register; set-default wins over a late event
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			err_q <= rif_pkg::RST_FLAGS;
		end else if (set_default) begin
			err_q <= rif_pkg::RST_FLAGS;
		end else begin
			err_q <= err_d;
		end
	end

	// mask registers, software written
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mask_main_q  <= rif_pkg::RST_MASK;
			mask_timer_q <= rif_pkg::RST_MASK;
			mask_err_q   <= rif_pkg::RST_MASK;
		end else if (set_default) begin
			mask_main_q  <= rif_pkg::RST_MASK;
			mask_timer_q <= rif_pkg::RST_MASK;
			mask_err_q   <= rif_pkg::RST_MASK;
		end else if (reg_wr) begin
			case (reg_addr)
				rif_pkg::OFS_MASK_MAIN: begin
					// summary positions have no mask and read zero
					mask_main_q <= reg_wdata & rif_pkg::MAIN_RC_BITS;
				end
				rif_pkg::OFS_MASK_TIMER: begin
					mask_timer_q <= reg_wdata;
				end
				rif_pkg::OFS_MASK_ERR: begin
					mask_err_q <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// read data mux; flag reads return the value before clearing
	always_comb begin
		case (reg_addr)
			rif_pkg::OFS_MASK_MAIN: begin
				rdata_d = mask_main_q;
			end
			rif_pkg::OFS_MASK_TIMER: begin
				rdata_d = mask_timer_q;
			end
			rif_pkg::OFS_MASK_ERR: begin
				rdata_d = mask_err_q;
			end
			rif_pkg::OFS_MAIN: begin
				rdata_d = main_q;
			end
			rif_pkg::OFS_TIMER: begin
				rdata_d = timer_q;
			end
			rif_pkg::OFS_ERR: begin
				rdata_d = err_q;
			end
			default: begin
				rdata_d = rif_pkg::RD_UNMAPPED;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= rif_pkg::RD_UNMAPPED;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= rif_pkg::RD_UNMAPPED;
		end
	end

	// request from registered flags; summary bits carry no mask of
	// their own, the secondary masks already decide for them
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(main_q & rif_pkg::MAIN_RC_BITS & ~mask_main_q) ||
				|(timer_q & ~mask_timer_q) ||
				|(err_q & ~mask_err_q);
		end
	end

endmodule // rif_flags
`default_nettype wire

// [verification/rif_flags_assertions.sv]
// assertion checker for the interrupt flag register block
`default_nettype none
module rif_flags_checker (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       set_default,
	input wire logic       bit_collision,
	input wire logic       cmd_done,
	input wire logic       crc_error,
	input wire logic       parity_error,
	input wire logic       soft_framing_error,
	input wire logic       hard_framing_error,
	input wire logic       wake_timeout,
	input wire logic       meas_valid,
	input wire logic       irq
);
	wire main_rd = reg_rd && reg_addr == 8'h17;
	wire err_rd = reg_rd && reg_addr == 8'h19;
	// any event that may set an error flag this cycle
	wire err_ev = crc_error | parity_error | soft_framing_error | hard_framing_error
		| wake_timeout | meas_valid;
	logic dct_mask_q;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// shadow of the command-done mask, so the request is expected only when unmasked
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			dct_mask_q <= 1'b0;
		else if (set_default)
			dct_mask_q <= 1'b0;
		else if (reg_wr && reg_addr == 8'h15)
			dct_mask_q <= reg_wdata[7];
	end

	a_sum_keep:
	assert property (main_rd ##1 main_rd |=>
		(reg_rdata[1:0] & $past(reg_rdata[1:0])) == $past(reg_rdata[1:0]))
		else $error("summary bit lost on a main read");
	a_sec_clr:
	assert property (main_rd && !err_ev ##1 err_rd |=> reg_rdata == 8'h00)
		else $error("error flags survived a main read");
	a_sum_drop:
	assert property (err_rd && !err_ev ##1 main_rd |=> !reg_rdata[0])
		else $error("error summary kept after its register was read");
	a_cmd_sum:
	assert property (cmd_done ##1 main_rd |=> reg_rdata[1])
		else $error("timer summary missing after command done");
	a_err_sum:
	assert property (crc_error ##1 !err_rd ##1 main_rd |=> reg_rdata[0])
		else $error("error summary missing after crc error");
	a_crc_flag:
	assert property (crc_error ##1 err_rd |=> reg_rdata[7])
		else $error("crc flag not set");
	a_coll_flag:
	assert property (bit_collision ##1 main_rd |=> reg_rdata[2])
		else $error("collision flag not set");
	a_dflt_zero:
	assert property (set_default && !err_ev ##1 err_rd |=> reg_rdata == 8'h00)
		else $error("flags not cleared by set default");
	a_irq_rise:
	assert property (cmd_done && !dct_mask_q && !set_default && !(reg_wr && reg_addr == 8'h15)
		##1 !set_default |=> irq)
		else $error("request not raised by unmasked event");
endmodule // rif_flags_checker

bind rif_flags rif_flags_checker u_rif_flags_checker (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .set_default, .bit_collision, .cmd_done, .crc_error,
	.parity_error, .soft_framing_error, .hard_framing_error, .wake_timeout, .meas_valid, .irq);
`default_nettype wire

// [verification/rif_host_model.sv]
// host software model: drives the register port and checks read data
`default_nettype none
module rif_host_model (
	input  wire logic       clk_sys,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	int         n_errors = 0;
	int         comparisons = 0;
	logic [7:0] exp_q[$];
	logic       taken_q = 1'b0;

	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	task automatic check(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	// rd and wr start just after an edge and return at the next, so strobes never collide; hold returns at once, idle after n edges
	task automatic hold();
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
	endtask
	task automatic idle(input int n);
		hold();
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask

	// read data stand only in the cycle after the strobe, so look mid-cycle there
	always @(posedge clk_sys) taken_q <= reg_rd;
	always @(negedge clk_sys) begin
		if (taken_q)
			check(exp_q.size() > 0 && reg_rdata === exp_q.pop_front(), "read data differ");
	end
endmodule // rif_host_model
`default_nettype wire

// [verification/tb_reader_irq_flag_registers.sv]
// testbench for the interrupt flag register block
`default_nettype none
module tb_reader_irq_flag_registers;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys = 1'b0;
	logic       rst_b = 1'b0;
	logic       set_default = 1'b0;
	logic       osc_enable = 1'b0;
	logic       osc_running = 1'b0;
	logic       rx_active = 1'b0;
	logic       tx_active = 1'b0;
	logic       fnf = 1'b0;
	logic       fne = 1'b0;
	logic [5:2] mev = 4'h0;
	logic [7:0] tev = 8'h00;
	logic [7:4] eev = 4'h0;
	logic       ext = 1'b0;
	logic       wto = 1'b0;
	logic       wirq = 1'b0;
	logic       mv = 1'b0;
	logic [1:0] mk = 2'h0;
	logic [7:0] mval = 8'h00;
	logic [7:0] mref = 8'h00;
	logic [7:0] mdel = 8'h00;
	int         seed = 32'hd63a;
	wire  [7:0] reg_addr;
	wire  [7:0] reg_wdata;
	wire  [7:0] reg_rdata;
	wire        reg_wr;
	wire        reg_rd;
	wire        irq;

	rif_host_model u_host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	rif_flags u_rif_flags (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.set_default, .osc_enable, .osc_running, .rx_active, .tx_active,
		.fifo_nearly_full(fnf), .fifo_nearly_empty(fne), .rx_start(mev[5]), .rx_end(mev[4]),
		.tx_end(mev[3]), .bit_collision(mev[2]), .cmd_done(tev[7]), .nrt_expired(tev[6]),
		.gpt_expired(tev[5]), .ext_field_async(ext), .ca_field_seen(tev[2]),
		.ca_guard_done(tev[1]), .target_rate_found(tev[0]), .crc_error(eev[7]),
		.parity_error(eev[6]), .soft_framing_error(eev[5]), .hard_framing_error(eev[4]),
		.wake_timeout(wto), .wake_irq_every(wirq), .meas_valid(mv), .meas_kind(mk),
		.meas_value(mval), .meas_ref(mref), .meas_delta(mdel), .irq);

	initial forever #50 clk_sys = ~clk_sys;

	// one event for one flag bit; register 3 is the transmit water-level path
	task automatic fire(input int r, input int b);
		logic [7:0] d;
		logic [7:0] rf;
		d = 8'($random(seed)) & 8'h3f;
		rf = 8'h80 | (8'($random(seed)) & 8'h3f);
		u_host.hold();
		case (r)
			0: if (b == 7) begin
				osc_enable <= 1'b1;
				osc_running <= 1'b1;
			end else if (b == 6) begin
				rx_active <= 1'b1;
				fnf <= 1'b1;
			end else mev[b] <= 1'b1;
			1: if (b == 4 || b == 3) ext <= (b == 4);
			else tev[b] <= 1'b1;
			2: if (b > 3) eev[b] <= 1'b1;
			else if (b == 3) begin
				wto <= 1'b1;
				wirq <= 1'b1;
			end else begin
				mv <= 1'b1;
				mk <= (b == 2) ? 2'h0 : (b == 1) ? 2'h1 : 2'h3;
				mdel <= d;
				mref <= rf;
				// below the reference, so the absolute difference is exercised
				mval <= rf - d - 8'h01;
			end
			default: begin
				tx_active <= 1'b1;
				fne <= 1'b1;
			end
		endcase
		@(posedge clk_sys);
		{osc_enable, osc_running, rx_active, tx_active, fnf, fne, wto, wirq, mv} <= 9'h000;
		mev <= 4'h0;
		tev <= 8'h00;
		eev <= 4'h0;
	endtask

	// request level is looked at mid-cycle, away from the edge that updates it
	task automatic chk(input logic e);
		u_host.hold();
		@(negedge clk_sys);
		u_host.check(irq === e, "request level differs");
		@(posedge clk_sys);
	endtask

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", u_host.comparisons, u_host.n_errors);
		if (u_host.n_errors == 0 && u_host.comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		u_host.idle(1);
		// flags and masks start clear; 0x1a is unmapped
		for (int a = 8'h14; a <= 8'h1a; a++) u_host.rd(8'(a), 8'h00);
		$display("test reset values done");
		// each event sets its own bit; a secondary read drops its summary
		for (int r = 0; r < 3; r++) begin
			for (int b = 7; b >= 0; b--) begin
				if (r == 0 && b < 2) continue;
				fire(r, b);
				if (r == 1) u_host.idle(4);
				u_host.rd(8'h17 + 8'(r), 8'h01 << b);
				if (r > 0) u_host.rd(8'h17, 8'h00);
			end
		end
		fire(3, 0);
		u_host.rd(8'h17, 8'h40);
		// a water level without its direction, or a running but disabled
		// oscillator, leaves the main flags clear
		u_host.hold();
		osc_running <= 1'b1;
		tx_active <= 1'b1;
		fnf <= 1'b1;
		@(posedge clk_sys);
		rx_active <= 1'b1;
		tx_active <= 1'b0;
		fnf <= 1'b0;
		fne <= 1'b1;
		@(posedge clk_sys);
		rx_active <= 1'b0;
		fne <= 1'b0;
		u_host.rd(8'h17, 8'h00);
		// enabling the running oscillator is what raises its flag
		osc_enable <= 1'b1;
		u_host.idle(1);
		u_host.rd(8'h17, 8'h80);
		{osc_enable, osc_running} <= 2'h0;
		// measurements at exactly the delta, the unused kind and an ungated timeout stay clear
		for (int k = 0; k < 4; k++) begin
			u_host.hold();
			mv <= 1'b1;
			mk <= 2'(k);
			mref <= 8'h80;
			mdel <= 8'h10;
			mval <= (k == 2) ? 8'hff : 8'h70;
			wto <= (k == 0);
			@(posedge clk_sys);
		end
		mv <= 1'b0;
		wto <= 1'b0;
		u_host.rd(8'h19, 8'h00);
		$display("test event flags done");
		// summaries outlive a main read and follow only their own register
		fire(0, 3);
		fire(2, 7);
		fire(1, 7);
		u_host.rd(8'h17, 8'h0b);
		chk(1'b1);
		u_host.rd(8'h17, 8'h03);
		u_host.rd(8'h17, 8'h03);
		u_host.rd(8'h19, 8'h00);
		u_host.rd(8'h17, 8'h02);
		u_host.rd(8'h18, 8'h00);
		u_host.rd(8'h17, 8'h00);
		chk(1'b0);
		$display("test summary bits done");
		// masked events stay flagged but keep the request low
		u_host.wr(8'h14, 8'hff);
		u_host.wr(8'h15, 8'hff);
		u_host.wr(8'h17, 8'hff);
		u_host.wr(8'h1a, 8'hff);
		u_host.rd(8'h14, 8'hfc);
		u_host.rd(8'h1a, 8'h00);
		fire(0, 2);
		fire(1, 7);
		u_host.idle(3);
		chk(1'b0);
		u_host.wr(8'h15, 8'h7f);
		u_host.idle(2);
		chk(1'b1);
		u_host.rd(8'h17, 8'h06);
		u_host.idle(2);
		chk(1'b0);
		$display("test masks done");
		// set default clears flags and masks
		fire(2, 5);
		u_host.hold();
		set_default <= 1'b1;
		@(posedge clk_sys);
		set_default <= 1'b0;
		u_host.rd(8'h19, 8'h00);
		u_host.rd(8'h15, 8'h00);
		u_host.rd(8'h17, 8'h00);
		u_host.idle(2);
		$display("test set default done");
		close_out();
	end

	// a hang is cut short and counted
	initial begin
		repeat (5000) @(posedge clk_sys);
		u_host.n_errors++;
		$display("unexpected at %0t: run did not finish", $time);
		close_out();
	end
endmodule // tb_reader_irq_flag_registers
`default_nettype wire
